/* common/ext_int_pkg.sv */
// Purpose: Shared constants for the external interrupt latch
// Assumes: 32-bit Avalon-MM data, byte addresses, 8-bit registers in low bits
// Notes: Register bit layout is fixed here; the bench stat() function repeats it as literal bits
package ext_int_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OPTION_CTRL_OFS = 8'h1C;
    localparam logic [7:0] STATUS_CTRL_OFS = 8'h20;
    // Status/control fields
    localparam int STAT_MODE_BIT = 0;
    localparam int STAT_MASK_BIT = 1;
    localparam int STAT_ACK_BIT = 2;
    localparam int STAT_PEND_BIT = 3;
    // Option/control fields
    localparam int OPT_PULLUP_DIS_BIT = 0;
    localparam int OPT_SHARED_IE_BIT = 1;
    localparam int OPT_SHARED_FLAG_BIT = 2;
    // Reset values
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_MASK = 1'b0;
    localparam logic RST_PULLUP_DIS = 1'b0;
    localparam logic RST_SHARED_IE = 1'b0;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
    // Vector pair taken by the CPU for this source
    localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFF8;
    localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFF9;
endpackage

/* hdl/external_interrupt_latch.sv */
// Purpose: External interrupt latch for a dedicated pin and a shared port pin
// Assumes: Pins are asynchronous; CPU strobes arrive on i_clk
// Notes: Registers reached over Avalon-MM, one wait state per access
//
// Function
// R1: Falling edge on dedicated active-low pin sets the interrupt latch.
// R2: CPU vector fetch acknowledges and clears the latch.
// R3: Writing 1 to write-only acknowledge bit clears latch; bit reads 0.
// R4: Reset clears latch and sensitivity bit, even with pin held low; here a pin held low sets the latch again just after reset release.
// R5: Sensitivity bit 1 means edges plus low levels; 0 means edges only.
// R6: Edge-only mode: request holds until fetch, acknowledge or reset.
// R7: Level mode: clears after acknowledge and pin high, either order.
// R8: Acknowledge never blocks later edges; a new edge latches again.
// R9: Mask bit 1 withholds the request from the priority logic.
// R10: Mask bit is read/write, resets to 0.
// R11: Serviced request makes the CPU fetch vector pair FFF8/FFF9.
// R12: Read-only pending flag shows the latch regardless of mask.
// R13: Shared pin is a source only when enabled and USB disabled.
// R14: Shared pin events OR into the same latch and controls.
// R15: Shared enable forces the shared pin to input with pullup.
// R16: Shared flag sets on its falling edge when enabled; cleared on read.
// R17: Pullup disable bit disconnects the dedicated pin pullup when 1.
// R18: In break state acknowledge acts only when break clear enable is 1.
// R19: Dedicated pin level goes to the CPU for branch-on-level tests.
// R20: Software should mask requests in the level-mode service routine.
// R21: Both pins are synchronised, edges found from consecutive samples.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
module external_interrupt_latch
    import ext_int_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_irq_pin_b,
    input wire logic i_shared_port_pin,
    input wire logic i_usb_module_enable,
    input wire logic i_vector_fetch,
    input wire logic i_break_state,
    input wire logic i_break_clear_enable,
    output logic o_int_request,
    output logic o_pin_level,
    output logic o_pin_pullup_en,
    output logic o_shared_pin_pullup_en,
    output logic o_shared_pin_force_input
);
    logic rst_meta_r;
    logic rst_sync_b_r;
    logic irq_meta_r;
    logic irq_sync_r;
    logic irq_prev_r;
    logic sh_meta_r;
    logic sh_sync_r;
    logic sh_prev_r;
    logic wait_r;
    logic mode_r;
    logic mask_r;
    logic pullup_dis_r;
    logic shared_ie_r;
    logic shared_flag_r;
    logic latch_r;
    logic ack_seen_r;
    logic shared_active;
    logic irq_edge;
    logic sh_edge;
    logic any_edge;
    logic level_low;
    logic wr_done;
    logic rd_take;
    logic rd_done;
    logic ack_wr;
    logic ack_any;
    logic sel_stat;
    logic sel_opt;

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b_r <= rst_meta_r;
        end
    end

    // Pin synchronisers; the meta stages feed only the next stage
    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            irq_meta_r <= 1'b1;
            irq_sync_r <= 1'b1;
            irq_prev_r <= 1'b1;
            sh_meta_r <= 1'b1;
            sh_sync_r <= 1'b1;
            sh_prev_r <= 1'b1;
        end else begin
            irq_meta_r <= i_irq_pin_b; // R21
            irq_sync_r <= irq_meta_r;
            irq_prev_r <= irq_sync_r;
            sh_meta_r <= i_shared_port_pin; // R21
            sh_sync_r <= sh_meta_r;
            sh_prev_r <= sh_sync_r;
        end
    end

    assign shared_active = shared_ie_r & ~i_usb_module_enable; // R13
    assign irq_edge = irq_prev_r & ~irq_sync_r; // R1 R21
    assign sh_edge = sh_prev_r & ~sh_sync_r; // R21
    assign any_edge = irq_edge | (shared_active & sh_edge); // R14
    assign level_low = ~irq_sync_r | (shared_active & ~sh_sync_r); // R14

    // Bus decode; accesses complete in the cycle waitrequest is low
    assign sel_stat = (i_avs_address == STATUS_CTRL_OFS);
    assign sel_opt = (i_avs_address == OPTION_CTRL_OFS);
    assign wr_done = i_avs_write & ~wait_r & i_avs_byteenable[0];
    assign rd_take = i_avs_read & wait_r;
    assign rd_done = i_avs_read & ~wait_r;
    assign ack_wr = wr_done & sel_stat & i_avs_writedata[STAT_ACK_BIT]; // R3
    // Break state blocks the acknowledge write unless clearing is enabled; vector fetch still clears
    assign ack_any = i_vector_fetch
                   | (ack_wr & (~i_break_state | i_break_clear_enable)); // R2 R18

    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~((i_avs_read | i_avs_write) & wait_r);
        end
    end

    // Read data captured one edge before it is presented
    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            o_avs_readdata <= RST_RDATA;
        end else if (rd_take) begin
            o_avs_readdata <= RST_RDATA;
            if (sel_stat) begin
                o_avs_readdata[STAT_MODE_BIT] <= mode_r;
                o_avs_readdata[STAT_MASK_BIT] <= mask_r;
                o_avs_readdata[STAT_ACK_BIT] <= 1'b0; // R3
                o_avs_readdata[STAT_PEND_BIT] <= latch_r; // R12
            end else if (sel_opt) begin
                o_avs_readdata[OPT_PULLUP_DIS_BIT] <= pullup_dis_r;
                o_avs_readdata[OPT_SHARED_IE_BIT] <= shared_ie_r;
                o_avs_readdata[OPT_SHARED_FLAG_BIT] <= shared_flag_r;
            end
        end
    end

    // Software control bits
    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            mode_r <= RST_MODE; // R4
            mask_r <= RST_MASK; // R10
            pullup_dis_r <= RST_PULLUP_DIS;
            shared_ie_r <= RST_SHARED_IE;
        end else if (wr_done) begin
            if (sel_stat) begin
                mode_r <= i_avs_writedata[STAT_MODE_BIT]; // R5
                mask_r <= i_avs_writedata[STAT_MASK_BIT]; // R10
            end
            if (sel_opt) begin
                pullup_dis_r <= i_avs_writedata[OPT_PULLUP_DIS_BIT]; // R17
                shared_ie_r <= i_avs_writedata[OPT_SHARED_IE_BIT];
            end
        end
    end

    // Only a flag value actually returned is cleared, so a new edge survives
    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            shared_flag_r <= 1'b0;
        end else if (shared_ie_r & sh_edge) begin
            shared_flag_r <= 1'b1; // R16
        end else if (rd_done & sel_opt & o_avs_readdata[OPT_SHARED_FLAG_BIT]) begin
            shared_flag_r <= 1'b0; // R16
        end
    end

    // Interrupt latch; a new edge always wins over any clear
    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            latch_r <= 1'b0; // R4
            ack_seen_r <= 1'b0;
        end else if (any_edge) begin
            latch_r <= 1'b1; // R1 R8 R14
            ack_seen_r <= 1'b0;
        end else if (mode_r) begin
            if ((ack_any | ack_seen_r) & ~level_low) begin
                latch_r <= 1'b0; // R7
                ack_seen_r <= 1'b0;
            end else if (ack_any & latch_r) begin
                ack_seen_r <= 1'b1; // R7
            end
        end else begin
            ack_seen_r <= 1'b0;
            if (ack_any) begin
                latch_r <= 1'b0; // R6
            end
        end
    end

    // Outputs to the CPU, pads and pullups
    always_ff @(posedge i_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            o_int_request <= 1'b0;
            o_pin_level <= 1'b1;
            o_pin_pullup_en <= 1'b0;
            o_shared_pin_pullup_en <= 1'b0;
            o_shared_pin_force_input <= 1'b0;
        end else begin
            o_int_request <= latch_r & ~mask_r; // R9 R11
            o_pin_level <= irq_sync_r; // R19
            o_pin_pullup_en <= ~pullup_dis_r; // R17
            o_shared_pin_pullup_en <= shared_ie_r; // R15
            o_shared_pin_force_input <= shared_ie_r; // R15
        end
    end

    assign o_avs_waitrequest = wait_r;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_sync_b_r);

    sequence bus_req_s;
        (i_avs_read | i_avs_write) & wait_r;
    endsequence
    sequence bus_done_s;
        !wait_r ##1 wait_r;
    endsequence

    bus_wait_a: assert property (bus_req_s |=> bus_done_s)
        else $error("access not answered after one wait state");

    edge_sets_a: assert property (irq_edge |=> latch_r) // R1
        else $error("falling edge did not set latch");

    fetch_clears_a: assert property (!mode_r && i_vector_fetch && !any_edge |=> !latch_r) // R2
        else $error("vector fetch did not clear latch");

    ack_read_a: assert property (rd_take && sel_stat |=> !o_avs_readdata[STAT_ACK_BIT]) // R3
        else $error("acknowledge bit read as one");

    sequence level_hold_s;
        mode_r && latch_r && level_low && !any_edge;
    endsequence
    level_hold_a: assert property (level_hold_s |=> latch_r) // R7
        else $error("level request dropped while pin low");

    mask_gate_a: assert property (latch_r && !mask_r |=> o_int_request) // R9
        else $error("unmasked request not presented");

    mask_block_a: assert property (mask_r |=> !o_int_request) // R9
        else $error("masked request presented");

    pend_flag_a: assert property (rd_take && sel_stat
        |=> o_avs_readdata[STAT_PEND_BIT] == $past(latch_r)) // R12
        else $error("pending flag differs from latch");

    shared_gate_a: assert property (!latch_r && !irq_edge && !(shared_active && sh_edge)
        |=> !latch_r) // R13
        else $error("latch set without a qualified edge");

    break_guard_a: assert property (i_break_state && !i_break_clear_enable && ack_wr
        && !i_vector_fetch && latch_r |=> latch_r) // R18
        else $error("acknowledge cleared latch in break state");

    flag_set_a: assert property (shared_ie_r && sh_edge |=> shared_flag_r) // R16
        else $error("shared pin flag not set");

    // Clear paths in both modes, then register and pad behaviour
    sequence edge_mode_ack_s;
        !mode_r && latch_r && ack_any && !any_edge;
    endsequence

    sequence level_release_s;
        mode_r && latch_r && (ack_any || ack_seen_r) && !level_low && !any_edge;
    endsequence

    sequence status_read_s;
        rd_take && sel_stat;
    endsequence

    sequence option_read_s;
        rd_take && sel_opt;
    endsequence

    sequence status_write_s;
        wr_done && sel_stat;
    endsequence

    ack_clears_a: assert property (edge_mode_ack_s |=> !latch_r) // R3 R6
        else $error("acknowledge did not clear edge request");

    edge_hold_a: assert property (!mode_r && latch_r && !ack_any |=> latch_r) // R6
        else $error("edge request dropped without acknowledge");

    level_clear_a: assert property (level_release_s |=> !latch_r) // R7
        else $error("level request kept after acknowledge and pin high");

    level_ack_a: assert property (mode_r && latch_r && ack_any && level_low && !any_edge
        |=> ack_seen_r) // R7
        else $error("acknowledge while pin low was lost");

    new_edge_a: assert property (ack_any && any_edge |=> latch_r) // R8
        else $error("edge with acknowledge did not latch");

    req_low_a: assert property (!latch_r |=> !o_int_request) // R9
        else $error("request shown without latch");

    mode_write_a: assert property (status_write_s
        |=> mode_r == $past(i_avs_writedata[STAT_MODE_BIT])) // R5
        else $error("sensitivity bit not written");

    mask_write_a: assert property (status_write_s
        |=> mask_r == $past(i_avs_writedata[STAT_MASK_BIT])) // R10
        else $error("mask bit not written");

    mask_read_a: assert property (status_read_s
        |=> o_avs_readdata[STAT_MASK_BIT] == $past(mask_r)) // R10
        else $error("mask bit read back wrong");

    usb_block_a: assert property (i_usb_module_enable && !irq_edge && !latch_r
        |=> !latch_r) // R13
        else $error("shared pin latched while usb enabled");

    shared_or_a: assert property (shared_active && sh_edge |=> latch_r) // R14
        else $error("shared pin edge did not latch");

    shared_pull_a: assert property (shared_ie_r
        |=> o_shared_pin_pullup_en && o_shared_pin_force_input) // R15
        else $error("shared pin not input with pullup");

    shared_free_a: assert property (!shared_ie_r
        |=> !o_shared_pin_pullup_en && !o_shared_pin_force_input) // R15
        else $error("shared pin held as input while disabled");

    flag_clear_a: assert property (rd_done && sel_opt && o_avs_readdata[OPT_SHARED_FLAG_BIT]
        && !(shared_ie_r && sh_edge) |=> !shared_flag_r) // R16
        else $error("shared flag not cleared by read");

    flag_read_a: assert property (option_read_s
        |=> o_avs_readdata[OPT_SHARED_FLAG_BIT] == $past(shared_flag_r)) // R16
        else $error("shared flag read back wrong");

    pullup_on_a: assert property (!pullup_dis_r |=> o_pin_pullup_en) // R17
        else $error("pin pullup off while enabled");

    pullup_off_a: assert property (pullup_dis_r |=> !o_pin_pullup_en) // R17
        else $error("pin pullup on while disabled");

    break_clear_a: assert property (i_break_state && i_break_clear_enable && ack_wr
        && !mode_r && !any_edge |=> !latch_r) // R18
        else $error("enabled break clear had no effect");

    pin_level_a: assert property (1'b1 |=> o_pin_level == $past(irq_sync_r)) // R19
        else $error("pin level output stale");

    unmapped_a: assert property (rd_take && !sel_stat && !sel_opt
        |=> o_avs_readdata == RST_RDATA)
        else $error("unmapped read not zero");
endmodule

/* tb/cpu_prio_model.sv */
// Purpose: CPU priority logic that vectors to a pending request
// Assumes: Request is a registered level on the shared clock
// Notes: Fetch after four counted request cycles, like an instruction finishing; the count carries over between requests
`timescale 1ns/1ns
module cpu_prio_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_auto,
    output logic o_fetch
);
    int cnt = 0;
    initial o_fetch = 1'b0;
    // Gap after a fetch skips one count, but the stale request still counts once before it drops
    always @(posedge i_clk) begin
        o_fetch <= 1'b0;
        if (i_req && i_auto && !o_fetch) begin
            cnt <= cnt + 1;
            if (cnt >= 3) begin
                o_fetch <= 1'b1;
                cnt <= 0;
            end
        end
    end
endmodule

/* tb/test_external_interrupt_latch.sv */
// Purpose: Self-checking bench for the external interrupt latch
// Assumes: One wait state per bus access, pins synchronised in the design
// Notes: Random mode and mask writes mixed with fixed corner cases
`timescale 1ns/1ns
module test_external_interrupt_latch;
    import ext_int_pkg::*;
    logic clk, rst_b, rd, wr, wsr, pin_b, sp, usb, vf, brk, bce, auto;
    logic req, lvl, pu, spu, sfi;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] wd, rdata, x;
    logic [3:0] be;
    int n_errors, n_tests;
    external_interrupt_latch dut (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wsr), .i_irq_pin_b(pin_b),
        .i_shared_port_pin(sp), .i_usb_module_enable(usb), .i_vector_fetch(vf),
        .i_break_state(brk), .i_break_clear_enable(bce), .o_int_request(req),
        .o_pin_level(lvl), .o_pin_pullup_en(pu), .o_shared_pin_pullup_en(spu),
        .o_shared_pin_force_input(sfi));
    cpu_prio_model cpu (.i_clk(clk), .i_req(req), .i_auto(auto), .o_fetch(vf));
    function automatic logic [31:0] stat(input logic m, input logic k, input logic p);
        return {28'h0, p, 1'b0, k, m};
    endfunction
    task automatic close_out;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input bit r, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk);
        rd <= r;
        wr <= !r;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            t++;
        end while (wsr !== 1'b0 && t < 50);
        if (t >= 50)
            n_errors++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(0, a, d, q);
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1, a, 32'h0, q);
        chk(q, e);
    endtask
    // High for a while, then a falling edge, then time to latch
    task automatic fall(input bit s);
        if (s) sp <= 1'b1;
        else pin_b <= 1'b1;
        repeat (4) @(posedge clk);
        if (s) sp <= 1'b0;
        else pin_b <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
    initial begin
        {rst_b, rd, wr, usb, brk, bce, auto} = 7'h0;
        {pin_b, sp} = 2'b11;
        adr = 8'h00;
        wd = 32'h0;
        be = 4'hF;
        n_errors = 0;
        n_tests = 0;
        x = $urandom(32'h7F58);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rdr(STATUS_CTRL_OFS, stat(0, 0, 0));
        rdr(OPTION_CTRL_OFS, 32'h0);
        chk(pu, 1'b1);
        for (int i = 0; i < 6; i++) begin
            x = $urandom;
            w(STATUS_CTRL_OFS, x);
            rdr(STATUS_CTRL_OFS, stat(x[0], x[1], 0));
        end
        w(STATUS_CTRL_OFS, 32'h0);
        fall(0);
        chk(req, 1'b1);
        chk(lvl, 1'b0);
        rdr(STATUS_CTRL_OFS, stat(0, 0, 1));
        w(STATUS_CTRL_OFS, 32'h2);
        repeat (2) @(posedge clk);
        chk(req, 1'b0);
        rdr(STATUS_CTRL_OFS, stat(0, 1, 1));
        w(STATUS_CTRL_OFS, 32'h6);
        rdr(STATUS_CTRL_OFS, stat(0, 1, 0));
        fall(0);
        rdr(STATUS_CTRL_OFS, stat(0, 1, 1));
        w(STATUS_CTRL_OFS, 32'h3);
        rdr(STATUS_CTRL_OFS, stat(1, 1, 1));
        w(STATUS_CTRL_OFS, 32'h7);
        rdr(STATUS_CTRL_OFS, stat(1, 1, 1));
        pin_b <= 1'b1;
        repeat (8) @(posedge clk);
        chk(lvl, 1'b1);
        rdr(STATUS_CTRL_OFS, stat(1, 1, 0));
        w(STATUS_CTRL_OFS, 32'h0);
        auto <= 1'b1;
        fall(0);
        rdr(STATUS_CTRL_OFS, stat(0, 0, 0));
        auto <= 1'b0;
        w(STATUS_CTRL_OFS, 32'h2);
        fall(0);
        brk <= 1'b1;
        w(STATUS_CTRL_OFS, 32'h6);
        rdr(STATUS_CTRL_OFS, stat(0, 1, 1));
        bce <= 1'b1;
        w(STATUS_CTRL_OFS, 32'h6);
        brk <= 1'b0;
        rdr(STATUS_CTRL_OFS, stat(0, 1, 0));
        w(OPTION_CTRL_OFS, 32'h2);
        repeat (2) @(posedge clk);
        chk({sfi, spu}, 2'b11);
        fall(1);
        rdr(STATUS_CTRL_OFS, stat(0, 1, 1));
        rdr(OPTION_CTRL_OFS, 32'h6);
        rdr(OPTION_CTRL_OFS, 32'h2);
        w(STATUS_CTRL_OFS, 32'h6);
        usb <= 1'b1;
        fall(1);
        rdr(STATUS_CTRL_OFS, stat(0, 1, 0));
        be <= 4'h0;
        w(OPTION_CTRL_OFS, 32'h1);
        be <= 4'hF;
        rdr(OPTION_CTRL_OFS, 32'h6);
        w(OPTION_CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk({pu, spu}, 2'b00);
        rdr(8'h40, 32'h0);
        w(STATUS_CTRL_OFS, 32'h1);
        fall(0);
        do_reset();
        rdr(STATUS_CTRL_OFS, stat(0, 0, 0));
        close_out();
    end
endmodule
